// ===== svwt_defs.svh
// Behaviour
// RULE1 - Clock monitor selectable, flags slow instruction clock
// RULE2 - Reset inhibits detectors, leaves armed, max window
// RULE3 - One keyed configuring write fixes window, monitor
// RULE4 - Later writes compared against stored bits 7:1; code also compares bit 0
// RULE5 - No service by upper limit raises fault
// RULE6 - Service before lower limit is a fault
// RULE7 - First accepted write counts as a service
// RULE8 - Fault pin pulled low, held 16 cycles
// RULE9 - Window restarts when fault pin returns high
// RULE10 - Service writes ignored while fault is active
// RULE11 - Clock fault holds pin, releases after 16
// RULE12 - Key field always reads back as zero
// RULE13 - Window detector frozen during halt and idle
// RULE14 - Clock monitor stays active in halt, idle
// RULE15 - RC option, delay clear: window resumes after halt
// RULE16 - Crystal or delay set: window restarts after halt
// RULE17 - Idle counter survives reset, pending on toggle
// RULE18 - Leaving idle performs a hardware service
// RULE19 - Initial service allowed anywhere in 64k window
// RULE20 - Matching fields restart, any mismatch faults
// RULE21 - Key field is bits 5:1, value 01100
// RULE22 - Bits 7:6 select 8k, 16k, 32k, 64k
// RULE23 - Lower limit fixed at 2048 cycles
// RULE24 - Either fault source drives the shared pin
`ifndef SVWT_DEFS_SVH
`define SVWT_DEFS_SVH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define SVWT_OFF_SERVICE 12'h000
`define SVWT_OFF_CTRL 12'h004
`define SVWT_OFF_STATUS 12'h008
`define SVWT_OFF_IDLECNT 12'h00c

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define SVWT_KEY 5'h0c
`define SVWT_SEL_RST 2'h3
`define SVWT_CM_RST 1'b1
`define SVWT_CTRL_DLY 0
`define SVWT_ST_PEND 0
`define SVWT_ST_WDF 1
`define SVWT_ST_CMF 2
`define SVWT_ST_CFG 3
`define SVWT_IDLE_TICK_BIT 12

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SVWT_LOWER_LIM 17'h00800
`define SVWT_UPPER_BASE 17'h02000
`define SVWT_HOLD_TICKS 5'h10
`define SVWT_CLK_MHZ 200
`define SVWT_CM_GAP_US 1000
`define SVWT_CM_GAP_CYCLES (`SVWT_CM_GAP_US * `SVWT_CLK_MHZ)

`endif

// ===== svwt_pkg.sv
`default_nettype none
package svwt_pkg;

  typedef struct packed {
    logic [1:0] sel;
    logic [4:0] key;
    logic cm_en;
  } svwt_svc_t;

  typedef enum logic [1:0] {
    FS_IDLE,
    FS_PULL,
    FS_HOLD,
    FS_RELEASE
  } svwt_fault_st_t;

  typedef enum logic [1:0] {
    CM_OK,
    CM_ERR,
    CM_TAIL
  } svwt_cm_st_t;

endpackage
`default_nettype wire

// ===== svwt_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "svwt_defs.svh"

module svwt_top #(
  parameter int unsigned CM_GAP_CYCLES = `SVWT_CM_GAP_CYCLES
) (
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic i_por_rst,
  input wire logic i_tc_tick,
  input wire logic i_halt_mode,
  input wire logic i_idle_mode,
  input wire logic i_xtal_option,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_supervisor_fault_out,
  output logic o_supervisor_fault_out,
  output logic o_supervisor_fault_out_oe
);

  // --------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------
  wire logic hit_svc;
  wire logic hit_ctrl;
  wire logic hit_stat;
  wire logic hit_icnt;
  wire logic mapped;
  wire logic setup;
  wire logic acc_wr;
  wire logic lane0;

  assign hit_svc = (i_paddr == `SVWT_OFF_SERVICE);
  assign hit_ctrl = (i_paddr == `SVWT_OFF_CTRL);
  assign hit_stat = (i_paddr == `SVWT_OFF_STATUS);
  assign hit_icnt = (i_paddr == `SVWT_OFF_IDLECNT);
  assign mapped = hit_svc | hit_ctrl | hit_stat | hit_icnt;
  assign setup = i_psel & ~i_penable;
  assign acc_wr = i_psel & i_penable & i_pwrite & mapped;
  assign lane0 = i_pstrb[0];

  assign o_pready = 1'b1;
  assign o_pslverr = i_psel & i_penable & ~mapped;

  // --------------------------------------------------------------
  // State
  // --------------------------------------------------------------
  svwt_pkg::svwt_svc_t cfg;
  svwt_pkg::svwt_fault_st_t fault_st;
  svwt_pkg::svwt_fault_st_t next_fault_st;
  svwt_pkg::svwt_cm_st_t cm_st;
  svwt_pkg::svwt_cm_st_t next_cm_st;
  logic configured;
  logic first_win;
  logic dly_bit;
  logic pending;
  logic halt_q;
  logic idle_q;
  logic [16:0] win_cnt;
  logic [16:0] next_win_cnt;
  logic [4:0] hold_cnt;
  logic [4:0] next_hold_cnt;
  logic [4:0] tail_cnt;
  logic [4:0] next_tail_cnt;
  logic [31:0] gap_cnt;
  logic [15:0] idle_cnt;
  logic [31:0] rd_data;

  // --------------------------------------------------------------
  // Instruction clock and modes
  // --------------------------------------------------------------
  wire logic eff_tick;
  wire logic halt_exit;
  wire logic idle_exit;
  wire logic halt_restart;
  wire logic win_hold;

  // Halt stops the instruction clock itself
  assign eff_tick = i_tc_tick & ~i_halt_mode; // [RULE14]
  assign halt_exit = halt_q & ~i_halt_mode;
  assign idle_exit = idle_q & ~i_idle_mode;
  assign halt_restart = halt_exit & (i_xtal_option | dly_bit); // [RULE16]
  assign win_hold = i_halt_mode | i_idle_mode; // [RULE13]

  // --------------------------------------------------------------
  // Service check
  // --------------------------------------------------------------
  wire logic fault_busy;
  wire logic svc_wr;
  wire logic [7:0] wbyte;
  wire logic key_ok;
  wire logic fields_ok;
  wire logic good;
  wire logic early;
  wire logic svc_ok;
  wire logic svc_bad;
  wire logic [16:0] upper_lim;
  wire logic timeout;
  wire logic wd_trig;
  wire logic restart;
  wire logic fault_done;

  assign fault_busy = (fault_st != svwt_pkg::FS_IDLE) |
                      (cm_st != svwt_pkg::CM_OK);
  assign svc_wr = acc_wr & hit_svc & lane0 & ~fault_busy; // [RULE10]
  assign wbyte = i_pwdata[7:0];
  assign key_ok = (wbyte[5:1] == `SVWT_KEY); // [RULE21]
  assign fields_ok = (wbyte[7:1] == {cfg.sel, cfg.key}) &
                     (wbyte[0] == cfg.cm_en); // [RULE4] [RULE20]
  assign good = configured ? fields_ok : key_ok; // [RULE3]
  // No lower limit in the window opened by reset
  assign early = ~first_win & (win_cnt < `SVWT_LOWER_LIM); // [RULE6] [RULE19] [RULE23]
  assign svc_ok = svc_wr & good & ~early;
  assign svc_bad = svc_wr & ~(good & ~early); // [RULE20]
  assign upper_lim = 17'(`SVWT_UPPER_BASE << cfg.sel); // [RULE22]
  assign timeout = ~win_hold & ~fault_busy &
                   (win_cnt >= upper_lim); // [RULE5]
  assign wd_trig = svc_bad | timeout;
  assign fault_done = (fault_st == svwt_pkg::FS_RELEASE) &
                      i_supervisor_fault_out; // [RULE9]
  assign restart = svc_ok | idle_exit | halt_restart | fault_done; // [RULE7] [RULE18]

  // --------------------------------------------------------------
  // Window counter
  // --------------------------------------------------------------
  always_comb begin
    next_win_cnt = win_cnt;
    if (restart) begin
      next_win_cnt = 17'h00000;
    end else if (eff_tick & ~win_hold & ~fault_busy & ~timeout) begin
      // Resumes from the held value after halt otherwise
      next_win_cnt = win_cnt + 17'h00001; // [RULE15]
    end
  end

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      win_cnt <= 17'h00000; // [RULE2]
    end else begin
      win_cnt <= next_win_cnt;
    end
  end

  // --------------------------------------------------------------
  // Service register
  // --------------------------------------------------------------
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cfg.sel <= `SVWT_SEL_RST; // [RULE2]
      cfg.key <= `SVWT_KEY;
      cfg.cm_en <= `SVWT_CM_RST; // [RULE2]
      configured <= 1'b0;
      first_win <= 1'b1;
    end else if (svc_ok & ~configured) begin
      cfg.sel <= wbyte[7:6]; // [RULE3]
      cfg.cm_en <= wbyte[0];
      configured <= 1'b1;
      first_win <= 1'b0;
    end
  end

  // --------------------------------------------------------------
  // Window fault sequence
  // --------------------------------------------------------------
  always_comb begin
    next_fault_st = fault_st;
    next_hold_cnt = hold_cnt;
    case (fault_st)
      svwt_pkg::FS_IDLE: begin
        if (wd_trig) begin
          next_fault_st = svwt_pkg::FS_PULL;
        end
      end
      svwt_pkg::FS_PULL: begin
        // Hold time counts from the pin seen low
        if (~i_supervisor_fault_out) begin
          next_fault_st = svwt_pkg::FS_HOLD; // [RULE8]
          next_hold_cnt = 5'h00;
        end
      end
      svwt_pkg::FS_HOLD: begin
        if (i_tc_tick) begin
          next_hold_cnt = hold_cnt + 5'h01;
          if (hold_cnt == `SVWT_HOLD_TICKS - 5'h01) begin
            next_fault_st = svwt_pkg::FS_RELEASE; // [RULE8]
          end
        end
      end
      svwt_pkg::FS_RELEASE: begin
        if (i_supervisor_fault_out) begin
          next_fault_st = svwt_pkg::FS_IDLE; // [RULE9]
        end
      end
      default: begin
        next_fault_st = svwt_pkg::FS_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      fault_st <= svwt_pkg::FS_IDLE;
      hold_cnt <= 5'h00;
    end else begin
      fault_st <= next_fault_st;
      hold_cnt <= next_hold_cnt;
    end
  end

  // --------------------------------------------------------------
  // Clock monitor
  // --------------------------------------------------------------
  wire logic gap_long;
  wire logic cm_err;

  assign gap_long = (gap_cnt >= CM_GAP_CYCLES);
  assign cm_err = cfg.cm_en & gap_long; // [RULE1]

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      gap_cnt <= 32'h00000000;
    end else if (eff_tick) begin
      gap_cnt <= 32'h00000000;
    end else if (~gap_long) begin
      gap_cnt <= gap_cnt + 32'h00000001; // [RULE1]
    end
  end

  always_comb begin
    next_cm_st = cm_st;
    next_tail_cnt = tail_cnt;
    case (cm_st)
      svwt_pkg::CM_OK: begin
        if (cm_err) begin
          next_cm_st = svwt_pkg::CM_ERR;
        end
      end
      svwt_pkg::CM_ERR: begin
        if (~cm_err) begin
          next_cm_st = svwt_pkg::CM_TAIL;
          next_tail_cnt = 5'h00;
        end
      end
      svwt_pkg::CM_TAIL: begin
        if (cm_err) begin
          next_cm_st = svwt_pkg::CM_ERR; // [RULE11]
        end else if (eff_tick) begin
          next_tail_cnt = tail_cnt + 5'h01;
          if (tail_cnt == `SVWT_HOLD_TICKS - 5'h01) begin
            next_cm_st = svwt_pkg::CM_OK; // [RULE11]
          end
        end
      end
      default: begin
        next_cm_st = svwt_pkg::CM_OK;
      end
    endcase
  end

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cm_st <= svwt_pkg::CM_OK; // [RULE2]
      tail_cnt <= 5'h00;
    end else begin
      cm_st <= next_cm_st;
      tail_cnt <= next_tail_cnt;
    end
  end

  // --------------------------------------------------------------
  // Fault pin
  // --------------------------------------------------------------
  wire logic wd_drive;
  wire logic cm_drive;

  assign wd_drive = (fault_st == svwt_pkg::FS_PULL) |
                    (fault_st == svwt_pkg::FS_HOLD);
  assign cm_drive = (cm_st != svwt_pkg::CM_OK);

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_supervisor_fault_out_oe <= 1'b0;
    end else begin
      o_supervisor_fault_out_oe <= wd_drive | cm_drive; // [RULE24] [RULE8]
    end
  end

  assign o_supervisor_fault_out = 1'b0;

  // --------------------------------------------------------------
  // Mode edges and control
  // --------------------------------------------------------------
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      halt_q <= 1'b0;
      idle_q <= 1'b0;
      dly_bit <= 1'b0;
    end else begin
      halt_q <= i_halt_mode;
      idle_q <= i_idle_mode;
      if (acc_wr & hit_ctrl & lane0) begin
        dly_bit <= i_pwdata[`SVWT_CTRL_DLY];
      end
    end
  end

  // --------------------------------------------------------------
  // Idle counter, kept over system reset
  // --------------------------------------------------------------
  wire logic pend_set;
  wire logic pend_clr;

  assign pend_set = eff_tick &
                    (idle_cnt[`SVWT_IDLE_TICK_BIT-1:0] == 12'hfff); // [RULE17]
  assign pend_clr = acc_wr & hit_stat & lane0 &
                    i_pwdata[`SVWT_ST_PEND];

  always_ff @(posedge i_core_clk or posedge i_por_rst) begin
    if (i_por_rst) begin
      idle_cnt <= 16'h0000;
    end else if (eff_tick) begin
      idle_cnt <= idle_cnt + 16'h0001; // [RULE17]
    end
  end

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pending <= 1'b0;
    end else if (pend_set) begin
      pending <= 1'b1;
    end else if (pend_clr) begin
      pending <= 1'b0; // [RULE17]
    end
  end

  // --------------------------------------------------------------
  // Read data
  // --------------------------------------------------------------
  wire logic [31:0] rd_svc;
  wire logic [31:0] rd_ctrl;
  wire logic [31:0] rd_stat;
  wire logic [31:0] rd_icnt;
  wire logic [31:0] rd_mux;

  assign rd_svc = {24'h000000, cfg.sel, 5'h00, cfg.cm_en}; // [RULE12]
  assign rd_ctrl = {31'h00000000, dly_bit};
  assign rd_stat = {28'h0000000, configured, cm_drive,
                    wd_drive, pending};
  assign rd_icnt = {16'h0000, idle_cnt};
  assign rd_mux = hit_svc ? rd_svc :
                  hit_ctrl ? rd_ctrl :
                  hit_stat ? rd_stat :
                  hit_icnt ? rd_icnt : 32'h00000000;

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rd_data <= 32'h00000000;
    end else if (setup & ~i_pwrite) begin
      rd_data <= rd_mux;
    end
  end

  assign o_prdata = rd_data;

endmodule // svwt_top
`default_nettype wire

// ===== svwt_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module svwt_monitor (
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic i_tc_tick,
  input wire logic i_halt_mode,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] o_prdata,
  input wire logic i_supervisor_fault_out,
  input wire logic o_supervisor_fault_out,
  input wire logic o_supervisor_fault_out_oe
);
  // --------------------------------
  // Ticks counted while pin held low
  // --------------------------------
  logic [5:0] hold_ticks;
  wire logic oe;
  wire logic pin;
  assign oe = o_supervisor_fault_out_oe;
  assign pin = i_supervisor_fault_out;
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      hold_ticks <= 6'h00;
    end else if (!oe || pin) begin
      hold_ticks <= 6'h00;
    end else if (i_tc_tick && !i_halt_mode && hold_ticks != 6'h3f) begin
      hold_ticks <= hold_ticks + 6'h01;
    end
  end
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);
  property p_drive_low;
    oe |-> !o_supervisor_fault_out;
  endproperty
  a_drive_low: assert property (p_drive_low)
    else $error("fault pin enabled but not driven low");
  property p_hold_min;
    $fell(oe) |-> $past(pin, 16) == 1'b0;
  endproperty
  a_hold_min: assert property (p_hold_min)
    else $error("fault pin released too early");
  property p_rose_hold;
    $rose(oe) |-> oe [*8];
  endproperty
  a_rose_hold: assert property (p_rose_hold)
    else $error("fault pin pulse too short");
  property p_tail_ticks;
    $fell(oe) |-> $past(i_tc_tick, 2);
  endproperty
  a_tail_ticks: assert property (p_tail_ticks)
    else $error("fault pin released without a tick");
  property p_key_read;
    i_psel && !i_penable && !i_pwrite && i_paddr == 12'h000
      |=> o_prdata[5:1] == 5'h00;
  endproperty
  a_key_read: assert property (p_key_read)
    else $error("key field read back nonzero");
  property p_hold_max;
    hold_ticks <= 6'h20;
  endproperty
  a_hold_max: assert property (p_hold_max)
    else $error("fault pin held over 32 ticks");
  property p_exit_reset;
    $fell(i_sys_rst) |-> !oe [*8];
  endproperty
  a_exit_reset: assert property (p_exit_reset)
    else $error("fault right after reset");
  property p_reset_quiet;
    disable iff (1'b0) i_sys_rst && $past(i_sys_rst) |-> !oe;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("fault pin driven in reset");
  c_rise: cover property ($rose(oe));
  c_fall: cover property ($fell(oe));
  c_hold: cover property (hold_ticks == 6'h10);
endmodule // svwt_monitor
`default_nettype wire

// ===== svwt_top_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n,e,g) begin comparisons++; if ((g) !== (e)) begin n_fail++; \
  $display("wrong value %s exp %h seen %h", n, e, g); end end
module svwt_top_test;
  logic clk = 1'b0, rst = 1'b1, por = 1'b1, tick = 1'b0, ten = 1'b1;
  logic halt = 1'b0, idle = 1'b0, xtal = 1'b0;
  logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, rdy, err, dout, oe, sl;
  logic [11:0] pa = 12'h000;
  logic [31:0] pwd = 32'h0, prd, rd;
  wire logic pin;
  int n_fail = 0, comparisons = 0;
  int cyc = 0;
  // --------------------------------
  // Pull-up on the shared fault pin
  // --------------------------------
  assign pin = oe ? dout : 1'b1;
  svwt_top #(.CM_GAP_CYCLES(200)) i_svwt_top (.i_core_clk(clk),
    .i_sys_rst(rst), .i_por_rst(por), .i_tc_tick(tick),
    .i_halt_mode(halt), .i_idle_mode(idle), .i_xtal_option(xtal),
    .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(pa),
    .i_pwdata(pwd), .i_pstrb(4'hf), .o_prdata(prd), .o_pready(rdy),
    .o_pslverr(err), .i_supervisor_fault_out(pin),
    .o_supervisor_fault_out(dout), .o_supervisor_fault_out_oe(oe));
  initial forever #2.5 clk = ~clk;
  always @(posedge clk) tick <= ten;
  always @(posedge clk) cyc <= cyc + 1;
  task automatic finish_test();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1; pwr <= w; pa <= a; pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    k = 0;
    do begin @(posedge clk); k++; end while (rdy !== 1'b1 && k < 16);
    if (k >= 16) begin
      n_fail++;
      finish_test();
    end
    rd = prd;
    sl = err;
    psel <= 1'b0; pen <= 1'b0;
  endtask
  task automatic rdw(input logic [11:0] a); apb(1'b0, a, 32'h0); endtask
  task automatic wr(input logic [7:0] d); apb(1'b1, 12'h000, {24'h0, d});
  endtask
  task automatic wait_oe(input logic v, input int b, output int n);
    n = 0;
    while (oe !== v && n < b) begin @(posedge clk); n++; end
    if (oe !== v) begin
      n_fail++;
      $display("wrong value fault pin wait exp %h seen %h", v, oe);
      finish_test();
    end
  endtask
  task automatic fault_cycle();
    int n;
    int t_on;
    wait_oe(1'b1, 4, n);
    t_on = cyc;
    rdw(12'h008);
    `CHK("wd flag", 1'b1, rd[1])
    wait_oe(1'b0, 100, n);
    `CHK("hold", 1'b1, cyc - t_on >= 16 && cyc - t_on <= 34)
  endtask
  task automatic t_reset();
    rdw(12'h000);
    `CHK("svc rst", 32'h000000c1, rd)
    rdw(12'h040);
    `CHK("unmapped", 1'b1, sl)
  endtask
  task automatic t_clock();
    int n;
    ten <= 1'b0;
    wait_oe(1'b1, 400, n);
    `CHK("cm gap", 1'b1, n >= 190)
    wr(8'h18);
    rdw(12'h008);
    `CHK("cm stat", 4'h4, rd[3:0])
    ten <= 1'b1;
    wait_oe(1'b0, 100, n);
    `CHK("cm tail", 1'b1, n >= 16 && n <= 34)
  endtask
  task automatic t_config();
    wr(8'h18);
    rdw(12'h008);
    `CHK("cfg", 1'b1, rd[3])
    rdw(12'h000);
    `CHK("svc cfg", 32'h0, rd)
    wr(8'h18);
    fault_cycle();
  endtask
  task automatic t_fields();
    logic [7:0] bad [3] = '{8'h58, 8'h1a, 8'h19};
    repeat (2100) @(posedge clk);
    wr(8'h18);
    repeat (4) @(posedge clk);
    `CHK("good svc", 1'b0, oe)
    foreach (bad[i]) begin
      repeat (2100) @(posedge clk);
      wr(bad[i]);
      fault_cycle();
    end
    rdw(12'h000);
    `CHK("svc kept", 32'h0, rd)
  endtask
  task automatic t_timeout();
    int n;
    wait_oe(1'b1, 9000, n);
    `CHK("upper", 1'b1, n >= 8170 && n <= 8200)
    fault_cycle();
  endtask
  // Case 0 resumes the window after halt, cases 1 and 2 restart it
  task automatic t_halt();
    for (int c = 0; c < 3; c++) begin
      apb(1'b1, 12'h004, {31'h0, c == 2});
      rdw(12'h004);
      `CHK("dly bit", c == 2, rd[0])
      xtal <= (c == 1);
      repeat (1000) @(posedge clk);
      halt <= 1'b1;
      repeat (300) @(posedge clk);
      halt <= 1'b0;
      repeat (1100) @(posedge clk);
      wr(8'h18);
      if (c == 0) begin
        repeat (4) @(posedge clk);
        `CHK("halt resume", 1'b0, oe)
      end else begin
        fault_cycle();
      end
    end
    xtal <= 1'b0;
  endtask
  task automatic t_idle();
    int k;
    k = 0;
    repeat (2100) @(posedge clk);
    idle <= 1'b1;
    repeat (9000) begin
      @(posedge clk);
      if (oe !== 1'b0) k++;
    end
    `CHK("idle hold", 0, k)
    idle <= 1'b0;
    repeat (1100) @(posedge clk);
    wr(8'h18);
    fault_cycle();
  endtask
  task automatic t_pending();
    logic [15:0] v;
    int n;
    rdw(12'h00c);
    // Step just past a wrap so the clear cannot meet a set
    repeat (13'h1007 - {1'b0, rd[11:0]}) @(posedge clk);
    rdw(12'h008);
    `CHK("pend set", 1'b1, rd[0])
    apb(1'b1, 12'h008, 32'h1);
    rdw(12'h008);
    `CHK("pend clr", 1'b0, rd[0])
    rdw(12'h00c);
    v = rd[15:0];
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rdw(12'h00c);
    `CHK("idle kept", 1'b1, rd[15:0] != v && rd[15:0] - v < 16'h0040)
    rdw(12'h000);
    `CHK("svc rst2", 32'h000000c1, rd)
    halt <= 1'b1;
    wait_oe(1'b1, 400, n);
    `CHK("halt cm", 1'b1, n >= 190)
    halt <= 1'b0;
    wait_oe(1'b0, 100, n);
    `CHK("halt tail", 1'b1, n >= 16 && n <= 34)
  endtask
  initial begin
    @(posedge clk);
    por <= 1'b0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_clock();
    t_config();
    t_fields();
    t_timeout();
    t_halt();
    t_idle();
    t_pending();
    finish_test();
  end
endmodule // svwt_top_test
bind svwt_top svwt_monitor i_svwt_monitor (.i_core_clk(i_core_clk),
  .i_sys_rst(i_sys_rst), .i_tc_tick(i_tc_tick), .i_halt_mode(i_halt_mode),
  .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
  .i_paddr(i_paddr), .o_prdata(o_prdata),
  .i_supervisor_fault_out(i_supervisor_fault_out),
  .o_supervisor_fault_out(o_supervisor_fault_out),
  .o_supervisor_fault_out_oe(o_supervisor_fault_out_oe));
`default_nettype wire
